// ---- src/seg_pin_pkg.sv ----
/*
 Package for the segment pin selection block: register offsets, field layouts,
 reset values and the variant code. Assumes a 32-bit classic Wishbone slave.
*/
package seg_pin_pkg;
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_SEL_LOW = 4'h4;
   localparam logic [3:0] ADDR_SEL_MID = 4'h8;
   localparam logic [3:0] ADDR_SEL_HIGH = 4'hC;
   localparam logic [7:0] RESET_SEL = 8'h00;
   localparam logic [7:0] MASK_LOW = 8'hFF;
   localparam logic [7:0] MASK_MID_SMALL = 8'h3F;
   localparam logic [7:0] MASK_MID_LARGE = 8'hFF;
   localparam logic [7:0] MASK_HIGH_SMALL = 8'h00;
   localparam logic [7:0] MASK_HIGH_LARGE = 8'h03;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int FIRST_SEG = 6;
   localparam int NUM_SEG_LARGE = 18;
   localparam int NUM_COM = 6;

   typedef enum logic [0:0] {
      VARIANT_SMALL = 1'b0,
      VARIANT_LARGE = 1'b1
   } variant_t;

   typedef struct packed {
      logic [7:0] high;
      logic [7:0] mid;
      logic [7:0] low;
   } seg_sel_t;
endpackage

// ---- src/lcd_segment_pin_select.sv ----
/*
 Segment pin selection for a software-driven panel driver. Holds the segment
 enable registers behind a classic Wishbone slave and muxes each shared pin
 between its segment drive and its other function. Assumes the panel drive
 levels and the other-function signals come from outside, synchronous to clk.
 The frame timing, bias current and common line selection live elsewhere.
*/
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module lcd_segment_pin_select
   import seg_pin_pkg::*;
#(
   parameter variant_t VARIANT = VARIANT_LARGE
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic [NUM_SEG_LARGE-1:0] segment_drive,
   input wire logic [NUM_SEG_LARGE-1:0] other_function,
   input wire logic [NUM_COM-1:0] common_drive,
   output logic [NUM_SEG_LARGE-1:0] segment_output_pin,
   output logic [NUM_COM-1:0] common_output_pin,
   output logic panel_driver_enable
);
   localparam logic [7:0] MASK_MID = (VARIANT == VARIANT_LARGE) ? MASK_MID_LARGE
                                                              : MASK_MID_SMALL;
   localparam logic [7:0] MASK_HIGH = (VARIANT == VARIANT_LARGE) ? MASK_HIGH_LARGE
                                                               : MASK_HIGH_SMALL;

   logic ctrl_en_ff;
   seg_sel_t sel_ff;
   logic ack_ff;
   logic [31:0] dat_ff;
   logic req;
   logic [NUM_SEG_LARGE-1:0] seg_enable;
   logic [7:0] nxt_rd;

   // Only the two known variants have a register map; anything else is refused.
   if (VARIANT != VARIANT_SMALL && VARIANT != VARIANT_LARGE)
   begin : g_bad_variant
      $error("Unsupported variant.");
   end

   if (NUM_SEG_LARGE != 8 + 8 + 2)
   begin : g_bad_width
      $error("Segment count does not match the select registers.");
   end

   // A request is answered one cycle after it is seen; ack falls the next cycle.
   // Masking req while ack is up keeps a master that is slow to drop stb from
   // being served twice.
   assign req = cyc_i && stb_i && !ack_ff;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ack_ff <= 1'b0;
      end
      else
      begin
         ack_ff <= req;
      end
   end

   // The module enable gates the commons and the segment-selected pins; pin selection is kept apart so
   // software can arrange the pins before switching the panel on.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_en_ff <= 1'b0;
      end
      else if (req && we_i && sel_i[0] && adr_i == ADDR_CTRL)
      begin
         ctrl_en_ff <= dat_i[CTRL_ENABLE_BIT];
      end
   end

   // Masks keep unimplemented bits at zero so reads return zero there.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sel_ff <= '{default: RESET_SEL};
      end
      else if (req && we_i && sel_i[0])
      begin
         unique case (adr_i)
            ADDR_SEL_LOW: sel_ff.low <= dat_i[7:0] & MASK_LOW;
            ADDR_SEL_MID: sel_ff.mid <= dat_i[7:0] & MASK_MID;
            ADDR_SEL_HIGH: sel_ff.high <= dat_i[7:0] & MASK_HIGH;
            default: ;
         endcase
      end
   end

   // Read data comes straight from the stored bytes, which already hold zero
   // wherever no select bit exists.
   always_comb
   begin
      unique case (adr_i)
         ADDR_CTRL: nxt_rd = {7'h00, ctrl_en_ff};
         ADDR_SEL_LOW: nxt_rd = sel_ff.low;
         ADDR_SEL_MID: nxt_rd = sel_ff.mid;
         ADDR_SEL_HIGH: nxt_rd = sel_ff.high;
         default: nxt_rd = 8'h00;
      endcase
   end

   // Unmapped addresses are acknowledged, reading zero and ignoring writes.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         dat_ff <= 32'h00000000;
      end
      else if (req && !we_i)
      begin
         dat_ff <= {24'h000000, nxt_rd};
      end
   end

   assign ack_o = ack_ff;
   assign dat_o = dat_ff;
   assign panel_driver_enable = ctrl_en_ff;

   // Bits 0..13 map to segment pins 6..19, 14..15 to 20..21, 16..17 to 22..23.
   assign seg_enable = {sel_ff.high[1:0], sel_ff.mid, sel_ff.low};

   // Gating the drive with the module enable, not the selects, keeps a pin from
   // jumping to its other function when the panel is switched off.
   always_comb
   begin
      for (int i = 0; i < NUM_SEG_LARGE; i++)
      begin
         if (!seg_enable[i])
         begin
            segment_output_pin[i] = other_function[i];
         end
         else
         begin
            segment_output_pin[i] = ctrl_en_ff & segment_drive[i];
         end
      end
      common_output_pin = ctrl_en_ff ? common_drive : {NUM_COM{1'b0}};
   end

   // Checks below watch only what this block drives; bus inputs are taken as given.
   mid_mask_a: assert property (@(posedge clk) disable iff (rst)
      (sel_ff.mid & ~MASK_MID) == 8'h00 && (sel_ff.high & ~MASK_HIGH) == 8'h00)
      else $error("Unimplemented select bit set.");
   write_low_a: assert property (@(posedge clk) disable iff (rst)
      req && we_i && sel_i[0] && adr_i == ADDR_SEL_LOW |=> sel_ff.low == $past(dat_i[7:0]))
      else $error("Low select write lost.");
   write_mid_a: assert property (@(posedge clk) disable iff (rst)
      req && we_i && sel_i[0] && adr_i == ADDR_SEL_MID
      |=> sel_ff.mid == ($past(dat_i[7:0]) & MASK_MID))
      else $error("Mid select write wrong.");
   write_high_a: assert property (@(posedge clk) disable iff (rst)
      req && we_i && sel_i[0] && adr_i == ADDR_SEL_HIGH
      |=> sel_ff.high == ($past(dat_i[7:0]) & MASK_HIGH))
      else $error("High select write wrong.");
   route_other_a: assert property (@(posedge clk) disable iff (rst)
      !seg_enable[0] |-> segment_output_pin[0] == other_function[0])
      else $error("Disabled pin not on other function.");
   top_pin_a: assert property (@(posedge clk) disable iff (rst)
      seg_enable[17] && !ctrl_en_ff |-> !segment_output_pin[17])
      else $error("Pin 23 driven while module off.");
   disabled_low_a: assert property (@(posedge clk) disable iff (rst)
      !ctrl_en_ff |-> common_output_pin == '0 && (segment_output_pin & seg_enable) == '0)
      else $error("Outputs not low while module off.");
   reset_clear_a: assert property (@(posedge clk)
      $fell(rst) |-> sel_ff == '0)
      else $error("Select bits not cleared by reset.");
   ack_once_a: assert property (@(posedge clk) disable iff (rst)
      ack_o |=> !ack_o)
      else $error("Ack held two cycles.");
   read_back_a: assert property (@(posedge clk) disable iff (rst)
      req && !we_i && adr_i == ADDR_SEL_HIGH |=> ack_o && dat_o[31:2] == '0)
      else $error("High read not zero above bit 1.");

   // Read data: the stored byte in the low lane, zero above it.
   read_low_a: assert property (@(posedge clk) disable iff (rst)
      req && !we_i && adr_i == ADDR_SEL_LOW |=> dat_o == {24'h000000, $past(sel_ff.low)})
      else $error("Low select read wrong.");
   read_mid_a: assert property (@(posedge clk) disable iff (rst)
      req && !we_i && adr_i == ADDR_SEL_MID
      |=> dat_o == {24'h000000, $past(sel_ff.mid) & MASK_MID})
      else $error("Mid select read wrong.");
   read_high_a: assert property (@(posedge clk) disable iff (rst)
      req && !we_i && adr_i == ADDR_SEL_HIGH
      |=> dat_o == {24'h000000, $past(sel_ff.high) & MASK_HIGH})
      else $error("High select read wrong.");
   read_ctrl_a: assert property (@(posedge clk) disable iff (rst)
      req && !we_i && adr_i == ADDR_CTRL |=> dat_o == {31'h00000000, $past(ctrl_en_ff)})
      else $error("Control read wrong.");
   read_unmapped_a: assert property (@(posedge clk) disable iff (rst)
      req && !we_i && adr_i[1:0] != 2'h0 |=> dat_o == 32'h00000000)
      else $error("Unmapped read not zero.");

   // Bus timing: one ack per request, always one cycle later.
   ack_follow_a: assert property (@(posedge clk) disable iff (rst)
      req |=> ack_o)
      else $error("Request not acknowledged next cycle.");
   ack_cause_a: assert property (@(posedge clk) disable iff (rst)
      ack_o |-> $past(req))
      else $error("Ack without request.");
   reset_ack_a: assert property (@(posedge clk)
      $fell(rst) |-> !ack_o && dat_o == 32'h00000000 && !ctrl_en_ff)
      else $error("Bus side not cleared by reset.");

   // Writes: one with lane 0 set to a mapped address lands in its own register only; any other access changes no register.
   write_ctrl_a: assert property (@(posedge clk) disable iff (rst)
      req && we_i && sel_i[0] && adr_i == ADDR_CTRL
      |=> ctrl_en_ff == $past(dat_i[CTRL_ENABLE_BIT]))
      else $error("Control write lost.");
   low_only_a: assert property (@(posedge clk) disable iff (rst)
      req && we_i && adr_i == ADDR_SEL_LOW |=> $stable(sel_ff.mid) && $stable(sel_ff.high))
      else $error("Low write touched another register.");
   mid_only_a: assert property (@(posedge clk) disable iff (rst)
      req && we_i && adr_i == ADDR_SEL_MID |=> $stable(sel_ff.low) && $stable(sel_ff.high))
      else $error("Mid write touched another register.");
   high_only_a: assert property (@(posedge clk) disable iff (rst)
      req && we_i && adr_i == ADDR_SEL_HIGH |=> $stable(sel_ff.low) && $stable(sel_ff.mid))
      else $error("High write touched another register.");
   ctrl_only_a: assert property (@(posedge clk) disable iff (rst)
      req && we_i && adr_i == ADDR_CTRL |=> $stable(sel_ff))
      else $error("Control write touched a select register.");
   lane_off_a: assert property (@(posedge clk) disable iff (rst)
      req && we_i && !sel_i[0] |=> $stable(sel_ff) && $stable(ctrl_en_ff))
      else $error("Write without byte lane took effect.");
   unmapped_write_a: assert property (@(posedge clk) disable iff (rst)
      req && we_i && adr_i[1:0] != 2'h0 |=> $stable(sel_ff) && $stable(ctrl_en_ff))
      else $error("Unmapped write took effect.");
   read_no_write_a: assert property (@(posedge clk) disable iff (rst)
      req && !we_i |=> $stable(sel_ff) && $stable(ctrl_en_ff))
      else $error("Read changed a register.");
   idle_hold_a: assert property (@(posedge clk) disable iff (rst)
      !req |=> $stable(sel_ff) && $stable(ctrl_en_ff))
      else $error("Register changed without a request.");
   read_hold_a: assert property (@(posedge clk) disable iff (rst)
      !(req && !we_i) |=> $stable(dat_o))
      else $error("Read data changed without a read.");
   write_ack_a: assert property (@(posedge clk) disable iff (rst)
      req && we_i |=> ack_o && $stable(dat_o))
      else $error("Write not acknowledged or read data disturbed.");

   // One set of checks per shared pin, so that a crossed bit shows at its own pin.
   for (genvar p = 0; p < NUM_SEG_LARGE; p++)
   begin : g_pin_chk
      pin_other_a: assert property (@(posedge clk) disable iff (rst)
         !seg_enable[p] |-> segment_output_pin[p] == other_function[p])
         else $error("Disabled pin not on other function.");
      pin_segment_a: assert property (@(posedge clk) disable iff (rst)
         seg_enable[p] && ctrl_en_ff |-> segment_output_pin[p] == segment_drive[p])
         else $error("Enabled pin not on segment drive.");
      pin_off_a: assert property (@(posedge clk) disable iff (rst)
         seg_enable[p] && !ctrl_en_ff |-> !segment_output_pin[p])
         else $error("Segment pin driven while module off.");
   end

   // Commons follow their drive only while the module is on.
   common_on_a: assert property (@(posedge clk) disable iff (rst)
      ctrl_en_ff |-> common_output_pin == common_drive)
      else $error("Common lines not following their drive.");

   // The small variant has no pins 20 to 23, so their selects never rise.
   if (VARIANT == VARIANT_SMALL)
   begin : g_small_chk
      small_top_a: assert property (@(posedge clk) disable iff (rst)
         seg_enable[NUM_SEG_LARGE-1:14] == 4'h0)
         else $error("Small variant enabled a missing pin.");
      small_mid_a: assert property (@(posedge clk) disable iff (rst)
         sel_ff.mid[7:6] == 2'h0)
         else $error("Small variant kept a missing mid bit.");
   end

   // The large variant keeps only the two low bits of the high register.
   if (VARIANT == VARIANT_LARGE)
   begin : g_large_chk
      large_high_a: assert property (@(posedge clk) disable iff (rst)
         sel_ff.high[7:2] == 6'h00)
         else $error("Large variant kept a missing high bit.");
   end

   write_cov: cover property (@(posedge clk) req && we_i && adr_i == ADDR_SEL_MID);
   read_cov: cover property (@(posedge clk) req && !we_i && adr_i == ADDR_SEL_LOW);
   drive_cov: cover property (@(posedge clk) ctrl_en_ff && seg_enable[0]);
   high_cov: cover property (@(posedge clk) req && we_i && adr_i == ADDR_SEL_HIGH);
   off_cov: cover property (@(posedge clk) !ctrl_en_ff && seg_enable[NUM_SEG_LARGE-1]);
endmodule
`default_nettype wire

// ---- tb/panel_electrodes.sv ----
/*
 Panel glass model: latches each segment and common line every clock.
 Assumes the pins of the segment selector, on the bench clock.
*/
`timescale 1ns/10ps
`default_nettype none
module panel_electrodes
   import seg_pin_pkg::*;
(
   input wire logic clk,
   input wire logic [NUM_SEG_LARGE-1:0] segment_output_pin,
   input wire logic [NUM_COM-1:0] common_output_pin,
   output logic [NUM_SEG_LARGE+NUM_COM-1:0] electrode_level
);
   always_ff @(posedge clk)
   begin
      electrode_level <= {common_output_pin, segment_output_pin};
   end
endmodule
`default_nettype wire

// ---- tb/lcd_segment_pin_select_tb.sv ----
/*
 Bench for the segment pin selector: both variants share one bus.
 Assumes the design package and the panel glass model.
*/
`timescale 1ns/10ps
`default_nettype none
module lcd_segment_pin_select_tb
   import seg_pin_pkg::*;
;
   logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack_l, ack_s, pen_l, pen_s;
   logic [3:0] adr = 4'h0, sel = 4'hF;
   logic [31:0] dat = 32'h0, rd_l, rd_s;
   logic [17:0] sdrv = 18'h0, oth = 18'h0, pin_l, pin_s;
   logic [5:0] cdrv = 6'h0, com_l, com_s;
   logic [23:0] elec;
   logic [7:0] sh_l[4] = '{4{8'h00}}, sh_s[4] = '{4{8'h00}};
   logic [15:0] lf = 16'h01D3;
   logic [63:0] q[$];
   int miscompares = 0, n_compared = 0;
   lcd_segment_pin_select #(.VARIANT(VARIANT_LARGE)) dut_u (.clk(clk), .rst(rst), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rd_l), .ack_o(ack_l),
      .segment_drive(sdrv), .other_function(oth), .common_drive(cdrv),
      .segment_output_pin(pin_l), .common_output_pin(com_l), .panel_driver_enable(pen_l));
   lcd_segment_pin_select #(.VARIANT(VARIANT_SMALL)) dut_s (.clk(clk), .rst(rst), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rd_s), .ack_o(ack_s),
      .segment_drive(sdrv), .other_function(oth), .common_drive(cdrv),
      .segment_output_pin(pin_s), .common_output_pin(com_s), .panel_driver_enable(pen_s));
   panel_electrodes glass_u (.clk(clk), .segment_output_pin(pin_l),
      .common_output_pin(com_l), .electrode_level(elec));
   always #20 clk = ~clk;
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic [7:0] msk(input int i, input logic sm);
      return i == 0 ? 8'h01 : i == 1 ? 8'hFF : i == 2 ? (sm ? 8'h3F : 8'hFF) : (sm ? 8'h00 : 8'h03);
   endfunction
   function automatic logic [17:0] pexp(input logic [7:0] s[4]);
      logic [17:0] v;
      v = {s[3][1:0], s[2], s[1]};
      return (v & sdrv & {18{s[0][0]}}) | (~v & oth);
   endfunction
   task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task acc(input logic w, input logic [3:0] a, input logic [7:0] d);
      int i;
      i = a[3:2];
      if (w && a[1:0] == 2'h0)
      begin
         sh_l[i] = d & msk(i, 0);
         sh_s[i] = d & msk(i, 1);
      end
      if (!w) q.push_back(a[1:0] != 2'h0 ? 64'h0 : {24'h0, sh_l[i], 24'h0, sh_s[i]});
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      dat <= {24'h0, d};
      @(posedge clk);
      for (int n = 0; n < 20 && ack_l !== 1'b1; n++) @(posedge clk);
      if (ack_l !== 1'b1) miscompares++;
      cyc <= 0;
      stb <= 0;
      @(posedge clk);
   endtask
   task rd_all();
      for (int a = 1; a < 16; a++) acc(0, a[3:0], 8'h00);
   endtask
   task pins();
      sdrv <= {lf[1:0], lf};
      oth <= {lf[3:2], ~lf};
      cdrv <= lf[9:4];
      lf = lfsr(lf);
      repeat (2) @(posedge clk);
      @(negedge clk);
      cmp("pins large", pexp(sh_l), pin_l);
      cmp("pins small", pexp(sh_s), pin_s);
      cmp("commons", sh_l[0][0] ? cdrv : 6'h0, com_l);
      cmp("enable", sh_s[0][0], pen_s);
      cmp("enable large", sh_l[0][0], pen_l);
      cmp("electrodes", {sh_l[0][0] ? cdrv : 6'h0, pexp(sh_l)}, elec);
      @(posedge clk);
   endtask
   task give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk)
      if (ack_l === 1'b1 && we === 1'b0)
      begin
         cmp("read large", q[0][63:32], rd_l);
         cmp("read small", q[0][31:0], rd_s);
         cmp("ack small", 32'h1, ack_s);
         void'(q.pop_front());
      end
   initial
   begin
      #200000;
      miscompares++;
      give_verdict();
   end
   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd_all();
      pins();
      $display("reset test done");
      repeat (6)
      begin
         for (int a = 0; a < 16; a += 4)
         begin
            acc(1, a[3:0], lf[7:0]);
            lf = lfsr(lf);
         end
         rd_all();
         pins();
      end
      $display("random test done");
      for (int a = 1; a < 16; a++) acc(1, a[3:0], 8'hFF);
      acc(1, 4'h0, 8'h01);
      rd_all();
      pins();
      acc(1, 4'h0, 8'h00);
      pins();
      $display("enable test done");
      give_verdict();
   end
endmodule
`default_nettype wire
